// [rtl/scs_consts.svh]
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

`define SCS_ADDR_W      9
`define SCS_DATA_W      16
`define SCS_CNT_W       5
`define SCS_DIR_IDX     5'h09
`define SCS_LAST_IDX    5'h19
`define SCS_TX_LAST     5'h10
`define SCS_SYNC_W      3
`define SCS_SYNC_RST    3'h2
`define SCS_SCK_BIT     0
`define SCS_SSN_BIT     1
`define SCS_MOSI_BIT    2
`define SCS_DIR_WRITE   1'h1

`endif

// [rtl/scs_pkg.sv]
`include "scs_consts.svh"

package scs_pkg;

  typedef enum logic [4:0] {
    SCS_IDLE  = 5'h01,
    SCS_ADDR  = 5'h02,
    SCS_WDATA = 5'h04,
    SCS_RDATA = 5'h08,
    SCS_DONE  = 5'h10
  } scs_state_e;

  typedef logic [`SCS_ADDR_W-1:0] scs_addr_t;
  typedef logic [`SCS_DATA_W-1:0] scs_data_t;

endpackage

// [rtl/scs_spi_slave.sv]
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_spi_slave #(
  parameter int ADDR_W = `SCS_ADDR_W,
  parameter int DATA_W = `SCS_DATA_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              sck_i,
  input  wire logic              ss_n_i,
  input  wire logic              mosi_i,
  output logic                   miso_o,
  output logic                   miso_oe_o,
  output scs_pkg::scs_addr_t     reg_addr_o,
  output scs_pkg::scs_data_t     reg_wdata_o,
  output logic                   reg_we_o,
  output logic                   reg_re_o,
  input  wire scs_pkg::scs_data_t reg_rdata_i,
  output logic                   busy_o
);

  import scs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [`SCS_SYNC_W-1:0] pin_raw;
  logic [`SCS_SYNC_W-1:0] pin_lvl;
  logic [`SCS_SYNC_W-1:0] pin_rise;
  logic [`SCS_SYNC_W-1:0] pin_fall;
  logic                   sck_rise;
  logic                   sck_fall;
  logic                   ss_high;
  logic                   mosi_bit;

  assign pin_raw[`SCS_SCK_BIT]  = sck_i;
  assign pin_raw[`SCS_SSN_BIT]  = ss_n_i;
  assign pin_raw[`SCS_MOSI_BIT] = mosi_i;

  scs_sync #(
    .WIDTH   (`SCS_SYNC_W),
    .RST_VAL (`SCS_SYNC_RST)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (pin_raw),
    .level_o   (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  assign sck_rise = pin_rise[`SCS_SCK_BIT];
  assign sck_fall = pin_fall[`SCS_SCK_BIT];
  assign ss_high  = pin_lvl[`SCS_SSN_BIT];
  assign mosi_bit = pin_lvl[`SCS_MOSI_BIT];

  ////////////////////////////////////////////////////////////////////////
  // frame state

  scs_state_e                state;
  logic [`SCS_CNT_W-1:0]     bit_cnt;
  logic [`SCS_CNT_W-1:0]     tx_cnt;
  logic [ADDR_W-1:0]         addr_sr;
  logic [DATA_W-1:0]         data_sr;
  logic [DATA_W-1:0]         tx_sr;
  logic                      dir_seen;
  logic                      last_seen;

  function automatic logic [DATA_W-1:0] shift_in(
    input logic [DATA_W-1:0] val,
    input logic              bit_in
  );
    shift_in = {val[DATA_W-2:0], bit_in};
  endfunction

  assign dir_seen  = sck_rise && (bit_cnt == `SCS_DIR_IDX);
  assign last_seen = sck_rise && (bit_cnt == `SCS_LAST_IDX);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= SCS_IDLE;
    end else if (ss_high) begin
      state <= SCS_IDLE;
    end else begin
      unique case (state)
        SCS_IDLE: begin
          state <= SCS_ADDR;
        end
        SCS_ADDR: begin
          if (dir_seen) begin
            if (mosi_bit == `SCS_DIR_WRITE) begin
              state <= SCS_WDATA;
            end else begin
              state <= SCS_RDATA;
            end
          end
        end
        SCS_WDATA: begin
          if (last_seen) begin
            state <= SCS_DONE;
          end
        end
        SCS_RDATA: begin
          if (sck_fall && (tx_cnt == `SCS_TX_LAST)) begin
            state <= SCS_DONE;
          end
        end
        SCS_DONE: begin
          state <= SCS_DONE;
        end
      endcase
    end
  end

  assign busy_o = (state != SCS_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // rising-edge bit counter and capture

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_cnt <= '0;
    end else if (ss_high || state == SCS_IDLE) begin
      bit_cnt <= '0;
    end else if (sck_rise && state != SCS_DONE) begin
      bit_cnt <= bit_cnt + `SCS_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_sr <= '0;
    end else if (sck_rise && state == SCS_ADDR && !dir_seen) begin
      addr_sr <= {addr_sr[ADDR_W-2:0], mosi_bit};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_sr <= '0;
    end else if (sck_rise && state == SCS_WDATA) begin
      data_sr <= shift_in(data_sr, mosi_bit);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bank side

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_addr_o <= '0;
    end else if (dir_seen && state == SCS_ADDR) begin
      reg_addr_o <= addr_sr;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_we_o    <= 1'h0;
      reg_wdata_o <= '0;
    end else if (last_seen && state == SCS_WDATA && !ss_high) begin
      reg_we_o    <= 1'h1;
      reg_wdata_o <= shift_in(data_sr, mosi_bit);
    end else begin
      reg_we_o    <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_re_o <= 1'h0;
    end else begin
      reg_re_o <= dir_seen && state == SCS_ADDR && !ss_high &&
                  (mosi_bit != `SCS_DIR_WRITE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data return on falling edges

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_sr <= '0;
    end else if (reg_re_o) begin
      tx_sr <= reg_rdata_i;
    end else if (sck_fall && state == SCS_RDATA &&
                 tx_cnt != '0 && tx_cnt != `SCS_TX_LAST) begin
      tx_sr <= {tx_sr[DATA_W-2:0], 1'h0};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_cnt <= '0;
    end else if (state != SCS_RDATA) begin
      tx_cnt <= '0;
    end else if (sck_fall && tx_cnt != `SCS_TX_LAST) begin
      tx_cnt <= tx_cnt + `SCS_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      miso_oe_o <= 1'h0;
    end else if (ss_high || state != SCS_RDATA) begin
      miso_oe_o <= 1'h0;
    end else if (sck_fall) begin
      miso_oe_o <= (tx_cnt != `SCS_TX_LAST);
    end
  end

  assign miso_o = tx_sr[DATA_W-1];

endmodule

// [rtl/scs_sync.sv]
`timescale 1ns/1ps
`include "scs_consts.svh"

module scs_sync #(
  parameter int          WIDTH   = `SCS_SYNC_W,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  ////////////////////////////////////////////////////////////////////////
  // three-flop chain, first flop feeds only the second
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // level accepted once stages two and three agree
  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_o <= RST_VAL;
    end else begin
      level_o <= (agree & stage3) | (~agree & level_o);
    end
  end

  assign rise_o = agree & stage3 & ~level_o;
  assign fall_o = agree & ~stage3 & level_o;

endmodule

// [sim/scs_master_model.sv]
`timescale 1ns/1ps
module scs_master_model (
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  import scs_pkg::*;
  logic last;
  logic miso_w;
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
    last = 1'b0;
  end
  always @(miso_i or miso_oe_i) if (miso_oe_i) last = miso_i;
  assign miso_w = miso_oe_i ? miso_i : ~last;
  task automatic xfer(input scs_addr_t a, input logic w, input scs_data_t d,
                      input int nb, output scs_data_t q);
    logic [25:0] fr;
    fr = {a, w, d};
    q = '0;
    ss_n_o = 1'b0;
    #160;
    for (int i = 0; i < nb; i++) begin
      mosi_o = fr[25-i];
      #80 sck_o = 1'b1;
      #80;
      if (i > 9) q = {q[14:0], miso_w};
      sck_o = 1'b0;
    end
    #160 ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #320;
  endtask
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      mosi_o = i[0];
      #80 sck_o = 1'b1;
      #80 sck_o = 1'b0;
    end
  endtask
endmodule

// [sim/scs_spi_slave_monitor.sv]
`timescale 1ns/1ps
module scs_spi_slave_monitor (
  input wire logic               ref_clk_i,
  input wire logic               rstn_i,
  input wire logic               ss_n_i,
  input wire logic               miso_oe_o,
  input wire logic               reg_we_o,
  input wire logic               reg_re_o,
  input wire scs_pkg::scs_data_t reg_wdata_o,
  input wire logic               busy_o
);
  import scs_pkg::*;
  logic [7:0] oe_cnt;
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) oe_cnt <= 8'h00;
    else oe_cnt <= miso_oe_o ? oe_cnt + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_sel_start;
    $fell(ss_n_i) && !busy_o;
  endsequence
  sequence s_sync_wait;
    !busy_o ##[1:6] busy_o;
  endsequence
  a_sync_frame_start:
    assert property (s_sel_start |=> s_sync_wait) else $error("start late");
  a_we_single:
    assert property (reg_we_o |=> !reg_we_o) else $error("we too long");
  a_re_single:
    assert property (reg_re_o |=> !reg_re_o) else $error("re too long");
  a_idle_quiet:
    assert property (ss_n_i [*8] |-> !miso_oe_o && !busy_o && !reg_we_o)
    else $error("active while deselected");
  a_we_selected:
    assert property (reg_we_o |-> !$past(ss_n_i, 4)) else $error("we unsel");
  a_wdata_hold:
    assert property (reg_we_o |=> $stable(reg_wdata_o)) else $error("wdata");
  a_read_drive:
    assert property (reg_re_o |-> ##[1:10] miso_oe_o) else $error("no drive");
  a_read_span:
    assert property ($fell(miso_oe_o) && !ss_n_i |->
                     oe_cnt >= 8'h7E && oe_cnt <= 8'h82)
    else $error("read span wrong");
  a_abort_release:
    assert property ($rose(ss_n_i) && miso_oe_o |-> ##[1:6] !miso_oe_o)
    else $error("miso held after deselect");
  a_oe_in_frame:
    assert property (miso_oe_o |-> busy_o) else $error("drive outside frame");
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  import scs_pkg::*;
  logic      ref_clk_i;
  logic      rstn_i;
  logic      sck_i;
  logic      ss_n_i;
  logic      mosi_i;
  logic      miso_o;
  logic      miso_oe_o;
  logic      reg_we_o;
  logic      reg_re_o;
  logic      busy_o;
  scs_addr_t reg_addr_o;
  scs_data_t reg_wdata_o;
  scs_data_t reg_rdata_i;
  scs_data_t bank [512];
  int        n_mismatch = 0;
  int        compares = 0;
  int        n_we = 0;
  int        n_re = 0;
  scs_spi_slave i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .sck_i(sck_i), .ss_n_i(ss_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .reg_addr_o(reg_addr_o),
    .reg_wdata_o(reg_wdata_o), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o),
    .reg_rdata_i(reg_rdata_i), .busy_o(busy_o));
  scs_master_model i_mst (.sck_o(sck_i), .ss_n_o(ss_n_i), .mosi_o(mosi_i),
    .miso_i(miso_o), .miso_oe_i(miso_oe_o));
  assign reg_rdata_i = bank[reg_addr_o];
  always @(posedge ref_clk_i) begin
    if (reg_we_o === 1'b1) bank[reg_addr_o] <= reg_wdata_o;
    n_we <= n_we + int'(reg_we_o === 1'b1);
    n_re <= n_re + int'(reg_re_o === 1'b1);
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string what, input scs_data_t e, input scs_data_t g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic t_write_read(input scs_addr_t a, input scs_data_t d);
    int w0;
    scs_data_t q;
    w0 = n_we;
    i_mst.xfer(a, 1'b1, d, 26, q);
    chk("we count", 16'(w0 + 1), 16'(n_we));
    chk("addr", {7'h00, a}, {7'h00, reg_addr_o});
    chk("wdata", d, reg_wdata_o);
    fork
      i_mst.xfer(a, 1'b0, ~d, 26, q);
      begin
        wait (reg_re_o === 1'b1);
        repeat (2) @(negedge ref_clk_i);
        bank[a] = d ^ 16'h5A5A;
      end
    join
    chk("rdata", d, q);
    chk("read no write", 16'(w0 + 1), 16'(n_we));
  endtask
  task automatic t_abort(input scs_addr_t a);
    int w0;
    scs_data_t q;
    scs_data_t old;
    w0 = n_we;
    old = bank[a];
    i_mst.xfer(a, 1'b1, ~old, 20, q);
    chk("we count", 16'(w0), 16'(n_we));
    chk("kept", old, bank[a]);
    i_mst.xfer(a, 1'b0, old, 14, q);
    chk("oe", 16'h0000, {15'h0000, miso_oe_o});
  endtask
  task automatic t_ignore();
    int w0;
    int r0;
    w0 = n_we;
    r0 = n_re;
    i_mst.noise(30);
    chk("we count", 16'(w0), 16'(n_we));
    chk("re count", 16'(r0), 16'(n_re));
    chk("busy", 16'h0000, {15'h0000, busy_o});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rstn_i = 1'b0;
    foreach (bank[i]) bank[i] = 16'h3C00 ^ 16'(i);
    repeat (3) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    chk("oe", 16'h0000, {15'h0000, miso_oe_o});
    t_write_read(9'h0A5, 16'hBEEF);
    t_write_read(9'h1FF, 16'hFFFF);
    t_write_read(9'h000, 16'h0000);
    t_abort(9'h0A5);
    t_ignore();
    t_write_read(9'h155, 16'h8001);
    give_verdict();
  end
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule
bind scs_spi_slave scs_spi_slave_monitor i_mon (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ss_n_i(ss_n_i),
  .miso_oe_o(miso_oe_o), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o),
  .reg_wdata_o(reg_wdata_o), .busy_o(busy_o));
